/* File: hdl/dmcr_pkg.sv */
package dmcr_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned NUM_REGS = 13;
   localparam logic [4:0] ADDR_SERIAL_AND_POWER_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_FILTER_AND_MODULATION_CONTROL = 5'h01;
   localparam logic [4:0] ADDR_INPUT_DATA_FORMAT_CONTROL = 5'h02;
   localparam logic [4:0] ADDR_CLOCK_OUTPUT_AND_DIVIDER = 5'h03;
   localparam logic [4:0] ADDR_LOOP_AND_CHARGE_PUMP_CONTROL = 5'h04;
   localparam logic [4:0] ADDR_IN_PHASE_FINE_GAIN = 5'h05;
   localparam logic [4:0] ADDR_IN_PHASE_COARSE_GAIN = 5'h06;
   localparam logic [4:0] ADDR_IN_PHASE_OFFSET_HIGH = 5'h07;
   localparam logic [4:0] ADDR_IN_PHASE_OFFSET_LOW_AND_DIRECTION = 5'h08;
   localparam logic [4:0] ADDR_QUADRATURE_FINE_GAIN = 5'h09;
   localparam logic [4:0] ADDR_QUADRATURE_COARSE_GAIN = 5'h0a;
   localparam logic [4:0] ADDR_QUADRATURE_OFFSET_HIGH = 5'h0b;
   localparam logic [4:0] ADDR_QUADRATURE_OFFSET_LOW_AND_DIRECTION = 5'h0c;
   localparam logic [4:0] ADDR_SILICON_VERSION = 5'h0d;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned BIT_SDIO_BIDIR = 7;
   localparam int unsigned BIT_LSB_FIRST = 6;
   localparam int unsigned BIT_SOFT_RESET = 5;
   localparam int unsigned BIT_SLEEP = 4;
   localparam int unsigned BIT_POWER_DOWN = 3;
   localparam int unsigned BIT_REF_MODE = 2;
   localparam int unsigned BIT_LOCK = 1;
   localparam int unsigned BIT_INTERP_LO = 6;
   localparam int unsigned BIT_MOD_LO = 4;
   localparam int unsigned BIT_ZERO_STUFF = 3;
   localparam int unsigned BIT_REAL_MIX = 2;
   localparam int unsigned BIT_MIX_SIGN = 1;
   localparam int unsigned BIT_PIN8_SELECT = 0;
   localparam int unsigned BIT_UNSIGNED_DATA = 7;
   localparam int unsigned BIT_ONE_PORT = 6;
   localparam int unsigned BIT_DATA_RATE_CLOCK_OUT_STRONG = 5;
   localparam int unsigned BIT_DATA_RATE_CLOCK_OUT_INVERT = 4;
   localparam int unsigned BIT_ONEPORT_INVERT = 2;
   localparam int unsigned BIT_CHANNEL_SELECT_INPUT_INVERT = 1;
   localparam int unsigned BIT_Q_FIRST = 0;
   localparam int unsigned BIT_RATE_CLK_ON_SDO = 7;
   localparam int unsigned BIT_DIVIDER_LO = 0;
   localparam int unsigned BIT_LOOP_ENABLE = 7;
   localparam int unsigned BIT_CP_MANUAL = 6;
   localparam int unsigned BIT_CP_CURRENT_LO = 0;
   localparam int unsigned BIT_OFFSET_DIR = 7;
   localparam int unsigned BIT_INSTR_READ = 7;

   // Writable bits; reserved and read-only bits are stored as zero
   localparam logic [NUM_REGS-1:0][7:0] WRITE_MASK = {
      8'h83, 8'hff, 8'h0f, 8'hff, 8'h83, 8'hff, 8'h0f, 8'hff,
      8'hc7, 8'h83, 8'hf7, 8'hff, 8'hdc};

   // Reset values, address 0x00 in the lowest slot
   localparam logic [NUM_REGS-1:0][7:0] RESET_VALUE = {
      8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h04, 8'h00};

   // Version nibble; the value is arbitrary
   localparam logic [3:0] VERSION_CODE = 4'h1;

   // Serial port sequencer
   typedef enum logic [1:0] {
      SER_IDLE,
      SER_INSTR,
      SER_DATA,
      SER_DONE
   } dmcr_ser_state_type;

endpackage : dmcr_pkg

/* File: hdl/dmcr_channel.sv */
`timescale 1ns/1ps
module dmcr_channel #(
   parameter int unsigned OFFSET_WIDTH = 10
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] fine_byte,
   input wire logic [7:0] coarse_byte,
   input wire logic [7:0] offset_high_byte,
   input wire logic [7:0] offset_low_byte,
   output logic [7:0] fine_gain,
   output logic [3:0] coarse_gain,
   output logic [OFFSET_WIDTH-1:0] offset_magnitude,
   output logic offset_to_complement
);

   initial begin
      if (OFFSET_WIDTH != 10) begin
         $error("dmcr_channel: offset is formed from 8 + 2 bits only");
      end
   end

   typedef struct packed {
      logic [7:0] fine;
      logic [3:0] coarse;
      logic [OFFSET_WIDTH-1:0] offset;
      logic dir;
   } dmcr_chan_state_type;

   dmcr_chan_state_type state_reg;
   dmcr_chan_state_type state_next;

   // ---------------------------------------------------------------
   // Field assembly
   // ---------------------------------------------------------------
   // High byte gives the upper eight bits, low byte bits 1:0 the rest
   always_comb begin
      state_next = state_reg;
      state_next.fine = fine_byte;
      state_next.coarse = coarse_byte[3:0];
      state_next.offset = {offset_high_byte, offset_low_byte[1:0]};
      state_next.dir = offset_low_byte[dmcr_pkg::BIT_OFFSET_DIR];
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign fine_gain = state_reg.fine;
   assign coarse_gain = state_reg.coarse;
   assign offset_magnitude = state_reg.offset;
   assign offset_to_complement = state_reg.dir;

   AST_OFFSET_MAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 offset_magnitude == {$past(offset_high_byte),
         $past(offset_low_byte[1:0])})
      else $error("offset magnitude not built from high and low bytes");

   AST_OFFSET_DIR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(offset_low_byte[7]) |=> offset_to_complement)
      else $error("offset direction did not follow its bit");

endmodule : dmcr_channel

/* File: hdl/dmcr_top.sv */
// What this block does
// - Thirteen byte registers 00h-0Ch plus version at 0Dh, serial access, reset to defaults.
// - Register 00h bit 2 selects one or two reference resistors.
// - Register 01h bit 0 puts lock or data-rate clock on pin.
// - Register 02h bit 4 inverts the data-rate clock output.
// - Register 02h bit 2 inverts the interleaved-port clock output.
// - Bit 7 of 08h/0Ch steers offset to positive or complement output.
// - Writing 00h bit 5 resets other registers, restarts; reads zero.
// - Register 01h bits 7:6 pick interpolation one, two, four, eight.
// - Register 01h bits 5:4 pick modulation none, half, quarter, eighth.
// - Offset magnitude is ten bits: high byte then two low bits.
`timescale 1ns/1ps
module dmcr_top (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic spi_csb_n,
   input wire logic spi_sclk,
   input wire logic spi_sdio_in,
   output logic spi_sdio_out,
   output logic spi_sdio_oe,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic pll_lock,
   input wire logic data_rate_clock_in,
   input wire logic interleave_clock_in,
   output logic shared_pin_out,
   output logic interleave_port_clock,
   output logic chip_restart,
   output logic sdio_bidirectional,
   output logic lsb_first,
   output logic sleep_mode,
   output logic power_down,
   output logic reference_resistor_mode,
   output logic [1:0] interpolation_rate,
   output logic [1:0] modulation_mode,
   output logic zero_stuffing,
   output logic real_mix,
   output logic mix_positive_sign,
   output logic unsigned_data,
   output logic one_port_mode,
   output logic data_rate_clock_strong,
   output logic channel_select_invert,
   output logic q_first,
   output logic rate_clock_on_sdo,
   output logic [1:0] loop_divider,
   output logic loop_enable,
   output logic charge_pump_manual,
   output logic [2:0] charge_pump_current,
   output logic [7:0] i_fine_gain,
   output logic [3:0] i_coarse_gain,
   output logic [9:0] i_offset_magnitude,
   output logic i_offset_to_complement,
   output logic [7:0] q_fine_gain,
   output logic [3:0] q_coarse_gain,
   output logic [9:0] q_offset_magnitude,
   output logic q_offset_to_complement
);

   typedef struct packed {
      logic [dmcr_pkg::NUM_REGS-1:0][7:0] regs;
      dmcr_pkg::dmcr_ser_state_type ser;
      logic [2:0] bit_cnt;
      logic [7:0] shift_in;
      logic [7:0] shift_out;
      logic [4:0] addr;
      logic rd;
      logic sclk_prev;
      logic sdo;
      logic sdio_out;
      logic sdio_oe;
      logic sdo_oe;
      logic restart;
      logic pin8;
      logic oneport;
   } dmcr_state_type;

   dmcr_state_type state_reg;
   dmcr_state_type state_next;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] byte_in;
   logic [7:0] rd_byte;
   logic [7:0] load_byte;
   logic wr_fire;
   logic [7:0] r0;
   logic [7:0] r1;
   logic [7:0] r2;

   assign r0 = state_reg.regs[0];
   assign r1 = state_reg.regs[1];
   assign r2 = state_reg.regs[2];

   // ---------------------------------------------------------------
   // Serial port and register file
   // ---------------------------------------------------------------
   // Serial pins are taken as synchronous, so one stage of history is
   // enough for edge detection. Only single-byte transfers are served.
   always_comb begin
      state_next = state_reg;
      sclk_rise = spi_sclk && !state_reg.sclk_prev;
      sclk_fall = !spi_sclk && state_reg.sclk_prev;
      wr_fire = 1'b0;
      state_next.sclk_prev = spi_sclk;
      state_next.restart = 1'b0;
      // Bit order follows the LSB-first option for both bytes
      if (r0[dmcr_pkg::BIT_LSB_FIRST]) begin
         byte_in = {spi_sdio_in, state_reg.shift_in[7:1]};
      end else begin
         byte_in = {state_reg.shift_in[6:0], spi_sdio_in};
      end
      // Read view: lock bit is live, version is fixed. The address comes
      // from the byte being shifted in, since it is only loaded on the
      // last instruction bit, before the address register has caught up.
      rd_byte = 8'h00;
      if (byte_in[4:0] == dmcr_pkg::ADDR_SILICON_VERSION) begin
         rd_byte = {4'h0, dmcr_pkg::VERSION_CODE};
      end else if (byte_in[4:0] < 5'(dmcr_pkg::NUM_REGS)) begin
         rd_byte = state_reg.regs[byte_in[3:0]];
         if (byte_in[4:0] == dmcr_pkg::ADDR_SERIAL_AND_POWER_CONTROL) begin
            rd_byte[dmcr_pkg::BIT_LOCK] = pll_lock;
         end
      end
      load_byte = rd_byte;
      if (r0[dmcr_pkg::BIT_LSB_FIRST]) begin
         load_byte = {<<{rd_byte}};
      end
      if (spi_csb_n) begin
         state_next.ser = dmcr_pkg::SER_IDLE;
         state_next.sdio_oe = 1'b0;
         state_next.sdo_oe = 1'b0;
      end else begin
         case (state_reg.ser)
            dmcr_pkg::SER_IDLE: begin
               state_next.ser = dmcr_pkg::SER_INSTR;
               state_next.bit_cnt = 3'h0;
            end
            dmcr_pkg::SER_INSTR: begin
               if (sclk_rise) begin
                  state_next.shift_in = byte_in;
                  state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
                  if (state_reg.bit_cnt == 3'h7) begin
                     state_next.ser = dmcr_pkg::SER_DATA;
                     state_next.rd = byte_in[dmcr_pkg::BIT_INSTR_READ];
                     state_next.addr = byte_in[4:0];
                     state_next.shift_out = load_byte;
                  end
               end
            end
            dmcr_pkg::SER_DATA: begin
               if (sclk_fall && state_reg.rd) begin
                  // Drive on falling edges so the host samples on rising
                  state_next.sdio_out = state_reg.shift_out[7];
                  state_next.sdo = state_reg.shift_out[7];
                  state_next.sdio_oe = r0[dmcr_pkg::BIT_SDIO_BIDIR];
                  state_next.sdo_oe = !r0[dmcr_pkg::BIT_SDIO_BIDIR];
                  state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
               end
               if (sclk_rise) begin
                  state_next.shift_in = byte_in;
                  state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
                  if (state_reg.bit_cnt == 3'h7) begin
                     state_next.ser = dmcr_pkg::SER_DONE;
                     wr_fire = !state_reg.rd;
                  end
               end
            end
            dmcr_pkg::SER_DONE: begin
               state_next.ser = dmcr_pkg::SER_DONE;
            end
            default: begin
               state_next.ser = dmcr_pkg::SER_IDLE;
            end
         endcase
      end
      // Writes keep reserved and read-only bits at zero
      if (wr_fire && state_reg.addr < 5'(dmcr_pkg::NUM_REGS)) begin
         state_next.regs[state_reg.addr[3:0]] = byte_in &
            dmcr_pkg::WRITE_MASK[state_reg.addr[3:0]];
         if (state_reg.addr == dmcr_pkg::ADDR_SERIAL_AND_POWER_CONTROL &&
             byte_in[dmcr_pkg::BIT_SOFT_RESET]) begin
            // Register 00h survives so the port settings stay valid
            for (int i = 1; i < dmcr_pkg::NUM_REGS; i++) begin
               state_next.regs[i] = dmcr_pkg::RESET_VALUE[i];
            end
            state_next.restart = 1'b1;
         end
      end
      // Shared pin and port clock; one cycle of added latency
      if (r1[dmcr_pkg::BIT_PIN8_SELECT]) begin
         state_next.pin8 = data_rate_clock_in ^
            r2[dmcr_pkg::BIT_DATA_RATE_CLOCK_OUT_INVERT];
      end else begin
         state_next.pin8 = pll_lock;
      end
      state_next.oneport = interleave_clock_in ^
         r2[dmcr_pkg::BIT_ONEPORT_INVERT];
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.regs <= dmcr_pkg::RESET_VALUE;
         state_reg.ser <= dmcr_pkg::SER_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign spi_sdio_out = state_reg.sdio_out;
   assign spi_sdio_oe = state_reg.sdio_oe;
   assign spi_sdo = state_reg.sdo;
   assign spi_sdo_oe = state_reg.sdo_oe;
   assign shared_pin_out = state_reg.pin8;
   assign interleave_port_clock = state_reg.oneport;
   assign chip_restart = state_reg.restart;
   assign sdio_bidirectional = r0[dmcr_pkg::BIT_SDIO_BIDIR];
   assign lsb_first = r0[dmcr_pkg::BIT_LSB_FIRST];
   assign sleep_mode = r0[dmcr_pkg::BIT_SLEEP];
   assign power_down = r0[dmcr_pkg::BIT_POWER_DOWN];
   assign reference_resistor_mode = r0[dmcr_pkg::BIT_REF_MODE];
   assign interpolation_rate = r1[dmcr_pkg::BIT_INTERP_LO +: 2];
   assign modulation_mode = r1[dmcr_pkg::BIT_MOD_LO +: 2];
   assign zero_stuffing = r1[dmcr_pkg::BIT_ZERO_STUFF];
   assign real_mix = r1[dmcr_pkg::BIT_REAL_MIX];
   assign mix_positive_sign = r1[dmcr_pkg::BIT_MIX_SIGN];
   assign unsigned_data = r2[dmcr_pkg::BIT_UNSIGNED_DATA];
   assign one_port_mode = r2[dmcr_pkg::BIT_ONE_PORT];
   assign data_rate_clock_strong = r2[dmcr_pkg::BIT_DATA_RATE_CLOCK_OUT_STRONG];
   assign channel_select_invert = r2[dmcr_pkg::BIT_CHANNEL_SELECT_INPUT_INVERT];
   assign q_first = r2[dmcr_pkg::BIT_Q_FIRST];
   assign rate_clock_on_sdo = state_reg.regs[3][dmcr_pkg::BIT_RATE_CLK_ON_SDO];
   assign loop_divider = state_reg.regs[3][dmcr_pkg::BIT_DIVIDER_LO +: 2];
   assign loop_enable = state_reg.regs[4][dmcr_pkg::BIT_LOOP_ENABLE];
   assign charge_pump_manual = state_reg.regs[4][dmcr_pkg::BIT_CP_MANUAL];
   assign charge_pump_current =
      state_reg.regs[4][dmcr_pkg::BIT_CP_CURRENT_LO +: 3];

   // In-phase and quadrature channel settings
   dmcr_channel #(.OFFSET_WIDTH(10)) u_in_phase (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .fine_byte(state_reg.regs[5]),
      .coarse_byte(state_reg.regs[6]),
      .offset_high_byte(state_reg.regs[7]),
      .offset_low_byte(state_reg.regs[8]),
      .fine_gain(i_fine_gain),
      .coarse_gain(i_coarse_gain),
      .offset_magnitude(i_offset_magnitude),
      .offset_to_complement(i_offset_to_complement)
   );

   dmcr_channel #(.OFFSET_WIDTH(10)) u_quadrature (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .fine_byte(state_reg.regs[9]),
      .coarse_byte(state_reg.regs[10]),
      .offset_high_byte(state_reg.regs[11]),
      .offset_low_byte(state_reg.regs[12]),
      .fine_gain(q_fine_gain),
      .coarse_gain(q_coarse_gain),
      .offset_magnitude(q_offset_magnitude),
      .offset_to_complement(q_offset_to_complement)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence seq_soft_reset_write;
      wr_fire && state_reg.addr == 5'h00 && byte_in[5];
   endsequence

   sequence seq_plain_write0;
      wr_fire && state_reg.addr == 5'h00 && !byte_in[5];
   endsequence

   AST_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n)
      seq_soft_reset_write |=> chip_restart && r1 == 8'h04 &&
      state_reg.regs[12] == 8'h00 ##1 !chip_restart)
      else $error("soft reset did not restore registers once");

   AST_RESET_BIT_ZERO: assert property (@(posedge sys_clk)
      disable iff (!reset_n) !r0[5] && !r0[1])
      else $error("self-clearing or status bit stored in register 00h");

   AST_REF_MODE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      seq_plain_write0 |=> reference_resistor_mode == $past(byte_in[2]))
      else $error("reference resistor mode not written");

   AST_FILTER_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_fire && state_reg.addr == 5'h01 |=>
      {interpolation_rate, modulation_mode} == $past(byte_in[7:4]))
      else $error("interpolation or modulation field not written");

   AST_PIN8_LOCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !r1[0] |=> shared_pin_out == $past(pll_lock))
      else $error("shared pin not showing lock");

   AST_DATA_RATE_CLOCK_OUT_INV: assert property (@(posedge sys_clk) disable iff (!reset_n)
      r1[0] |=> shared_pin_out == ($past(data_rate_clock_in) ^ $past(r2[4])))
      else $error("data-rate clock polarity wrong");

   AST_ONEPORT_INV: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 interleave_port_clock ==
      ($past(interleave_clock_in) ^ $past(r2[2])))
      else $error("interleaved-port clock polarity wrong");

   AST_VERSION_RO: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_fire && state_reg.addr == 5'h0d |=> $stable(state_reg.regs))
      else $error("write to version register changed storage");

endmodule : dmcr_top

/* File: testbench/dmcr_host_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Serial host that masters the configuration port
// ---------------------------------------------------------------
module dmcr_host_model (
   input wire logic sys_clk,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   output logic spi_csb_n,
   output logic spi_sclk,
   output logic spi_sdio_in
);
   // Idle levels: port deselected, clock parked low between frames
   initial begin
      spi_csb_n = 1'b1;
      spi_sclk = 1'b0;
      spi_sdio_in = 1'b0;
   end

   // One frame: instruction byte then data byte, MSB first
   // Sclk phases last three cycles so the device sees every level
   task automatic xfer(input logic [7:0] instr, input logic [7:0] wdata,
         output logic [7:0] rdata);
      logic [15:0] frame;
      frame = {instr, wdata};
      rdata = 8'h00;
      @(posedge sys_clk);
      spi_csb_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      for (int i = 15; i >= 0; i--) begin
         spi_sclk <= 1'b0;
         spi_sdio_in <= frame[i];
         repeat (3) @(posedge sys_clk);
         spi_sclk <= 1'b1;
         // A read bit on a released line shows as unknown and mismatches
         if (i < 8) begin
            rdata[i] = spi_sdo_oe ? spi_sdo : 1'bx;
         end
         repeat (3) @(posedge sys_clk);
      end
      spi_sclk <= 1'b0;
      spi_sdio_in <= ~frame[0]; // Released data line loses its last value
      repeat (2) @(posedge sys_clk);
      spi_csb_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask : xfer
endmodule : dmcr_host_model

/* File: testbench/dmcr_top_tb.sv */
`timescale 1ns/1ps
module dmcr_top_tb;
   logic sys_clk, reset_n, pll_lock, rate_in, ilv_in;
   logic csb_n, sclk, sdio, sdo, sdo_oe, shared, ilv_out, restart;
   logic ref_mode, i_dir, q_dir;
   logic [1:0] interp, modul;
   logic [9:0] i_off, q_off;
   int mismatches, samples_checked, restarts;

   // ---------------------------------------------------------------
   // Clock, design and host
   // ---------------------------------------------------------------
   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;

   dmcr_top i_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .spi_csb_n(csb_n),
      .spi_sclk(sclk), .spi_sdio_in(sdio), .spi_sdio_out(), .spi_sdio_oe(),
      .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .pll_lock(pll_lock),
      .data_rate_clock_in(rate_in), .interleave_clock_in(ilv_in),
      .shared_pin_out(shared), .interleave_port_clock(ilv_out),
      .chip_restart(restart), .sdio_bidirectional(), .lsb_first(),
      .sleep_mode(), .power_down(), .reference_resistor_mode(ref_mode),
      .interpolation_rate(interp), .modulation_mode(modul),
      .zero_stuffing(), .real_mix(), .mix_positive_sign(),
      .unsigned_data(), .one_port_mode(), .data_rate_clock_strong(),
      .channel_select_invert(), .q_first(), .rate_clock_on_sdo(),
      .loop_divider(), .loop_enable(), .charge_pump_manual(),
      .charge_pump_current(), .i_fine_gain(), .i_coarse_gain(),
      .i_offset_magnitude(i_off), .i_offset_to_complement(i_dir),
      .q_fine_gain(), .q_coarse_gain(), .q_offset_magnitude(q_off),
      .q_offset_to_complement(q_dir));

   dmcr_host_model i_host (
      .sys_clk(sys_clk), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
      .spi_csb_n(csb_n), .spi_sclk(sclk), .spi_sdio_in(sdio));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Restart pulses are counted so a stuck or doubled pulse shows
   always @(posedge sys_clk) begin
      if (restart === 1'b1) begin
         restarts++;
      end
   end

   task automatic chk(input logic [9:0] got, input logic [9:0] exp,
         input string what);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time,
            what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] unused;
      i_host.xfer({3'b000, a}, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] got;
      i_host.xfer({3'b100, a}, 8'h00, got);
      chk({2'b00, got}, {2'b00, exp}, "register read");
   endtask : rd_chk

   // Defaults; the lock bit is live, so it follows the input
   function automatic logic [7:0] dflt(input int a);
      if (a == 13) begin
         return {4'h0, dmcr_pkg::VERSION_CODE};
      end
      return dmcr_pkg::RESET_VALUE[a] |
         ((a == 0) ? {6'h00, pll_lock, 1'b0} : 8'h00);
   endfunction : dflt

   function automatic logic [7:0] pat(input int a);
      return {a[3:0], ~a[3:0]};
   endfunction : pat

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      pll_lock = 1'b0;
      rate_in = 1'b0;
      ilv_in = 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int a = 0; a < 14; a++) begin
         rd_chk(a[4:0], dflt(a));
      end
      // Lock bit tracks the input and ignores host writes
      pll_lock <= 1'b1;
      rd_chk(5'h00, 8'h02);
      pll_lock <= 1'b0;
      wr(5'h00, 8'h02);
      rd_chk(5'h00, 8'h00);
      wr(5'h0d, 8'hff);
      rd_chk(5'h0d, dflt(13));
      wr(5'h1f, 8'hff);
      rd_chk(5'h1f, 8'h00);
      // Fill every writable register, bit 5 of 00h kept clear
      wr(5'h00, 8'h1c);
      for (int a = 1; a < 13; a++) begin
         wr(a[4:0], pat(a));
      end
      rd_chk(5'h00, 8'h1c);
      for (int a = 1; a < 13; a++) begin
         rd_chk(a[4:0], pat(a) & dmcr_pkg::WRITE_MASK[a]);
      end
      chk({9'h000, ref_mode}, 10'h001, "resistor mode");
      chk(i_off, {pat(7), pat(8)[1:0]}, "i offset");
      chk(q_off, {pat(11), pat(12)[1:0]}, "q offset");
      chk({9'h000, i_dir}, {9'h000, pat(8)[7]}, "i steer");
      chk({9'h000, q_dir}, {9'h000, pat(12)[7]}, "q steer");
      // Every rate and modulation code, pin select and both inversions
      rate_in <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(5'h01, {c[1:0], ~c[1:0], 3'b000, c[0]});
         wr(5'h02, {3'b000, c[1], 1'b0, c[0], 2'b00});
         pll_lock <= c[1];
         ilv_in <= c[1];
         repeat (3) @(posedge sys_clk);
         chk({8'h00, interp}, {8'h00, c[1:0]}, "interp");
         chk({8'h00, modul}, {8'h00, ~c[1:0]}, "modulation");
         chk({9'h000, shared}, {9'h000, c[0] ? ~c[1] : c[1]}, "pin");
         chk({9'h000, ilv_out}, {9'h000, c[1] ^ c[0]}, "ilv clk");
      end
      // Software reset spares 00h, restores the rest, reads back zero
      pll_lock <= 1'b0;
      restarts = 0;
      wr(5'h00, 8'h3c);
      chk(10'(restarts), 10'h001, "restart pulses");
      rd_chk(5'h00, 8'h1c);
      for (int a = 1; a < 13; a++) begin
         rd_chk(a[4:0], dflt(a));
      end
      chk(i_off, 10'h000, "i offset after reset");
      chk({9'h000, i_dir}, 10'h000, "i steer after reset");
      close_out();
   end

   // Whole run is about 7200 cycles; over five times that means a hang
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      close_out();
   end
endmodule : dmcr_top_tb
